// File: hw/gauge_pkg.sv
package gauge_pkg;
    // =========================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int HZ_PER_MHZ = 1_000_000;
    localparam int CYC_PER_US = CLK_HZ / HZ_PER_MHZ;
    localparam int RTZ_STEP_US = 4096;
    localparam int RTZ_STEP_CYC = RTZ_STEP_US * CYC_PER_US;
    localparam int TMR_W = 20;
    localparam logic [7:0] VEL_MAX = 8'h10;
    localparam logic [4:0] PH_LAST = 5'h17;
    // =========================================
    // serial word fields and reset values
    localparam int SEL_LSB = 8;
    localparam int KIND_BIT = 15;
    localparam int GSEL_BIT = 12;
    localparam int EN_LSB = 0;
    localparam int RTZ_LSB = 2;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [11:0] POS_RESET = 12'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [14:0] ACC_RESET = 15'h0000;
    localparam logic [14:0] ACC_PRELOAD = 15'h7fff;
    localparam logic [12:0] SYNC_RESET = 13'h0001;
    localparam logic [3:0] PREV_RESET = 4'h1;

    typedef enum logic [2:0] {
        VIEW_DEV = 3'b000,
        VIEW_ACC = 3'b001,
        VIEW_POS0 = 3'b010,
        VIEW_POS1 = 3'b011,
        VIEW_VEL = 3'b100
    } view_t;

    // selector nibble to status view
    function automatic view_t view_of(input logic [3:0] s);
        if (!s[3]) view_of = VIEW_DEV;
        else if (!s[2]) view_of = VIEW_ACC;
        else if (s[1]) view_of = VIEW_VEL;
        else if (s[0]) view_of = VIEW_POS1;
        else view_of = VIEW_POS0;
    endfunction

    // step interval in microseconds per velocity index
    function automatic logic [14:0] step_us(input logic [7:0] v);
        case (v)
            8'h01: step_us = 15'h6a51;
            8'h02: step_us = 15'h3527;
            8'h03: step_us = 15'h2c07;
            8'h04: step_us = 15'h1f22;
            8'h05: step_us = 15'h16e2;
            8'h06: step_us = 15'h11d4;
            8'h07: step_us = 15'h0e88;
            8'h08: step_us = 15'h0c3c;
            8'h09: step_us = 15'h0a8d;
            8'h0a: step_us = 15'h0945;
            8'h0b: step_us = 15'h0843;
            8'h0c: step_us = 15'h0774;
            8'h0d: step_us = 15'h06c9;
            8'h0e: step_us = 15'h063a;
            8'h0f: step_us = 15'h05c1;
            default: step_us = 15'h0559;
        endcase
    endfunction
endpackage

// File: hw/step_if.sv
`timescale 1ns/100ps
`default_nettype none
interface step_if;
    logic pulse;
    logic cw;
    modport src(output pulse, output cw);
    modport dst(input pulse, input cw);
endinterface
`default_nettype wire

// File: hw/microstep_seq.sv
`timescale 1ns/100ps
`default_nettype none
module microstep_seq (
    input wire logic clk,
    input wire logic rst_b,
    step_if.dst stp,
    output logic [4:0] phase
);
    import gauge_pkg::*;
    logic [4:0] phase_d, phase_q;

    // =========================================
    // 24-position coil pattern index
    always_comb begin
        phase_d = phase_q;
        if (stp.pulse) begin
            if (stp.cw) phase_d = (phase_q == PH_LAST) ? 5'h00 : phase_q + 5'h01;
            else phase_d = (phase_q == 5'h00) ? PH_LAST : phase_q - 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) phase_q <= 5'h00;
        else phase_q <= phase_d;
    end

    assign phase = phase_q;

    property p_wrap;
        @(posedge clk) disable iff (!rst_b)
        stp.pulse && stp.cw && phase_q == PH_LAST |=> phase_q == 5'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("cw wrap missed");

    property p_ccw;
        @(posedge clk) disable iff (!rst_b)
        stp.pulse && !stp.cw && phase_q != 5'h00 |=> phase_q == $past(phase_q) - 5'h01;
    endproperty
    a_ccw: assert property (p_ccw) else $error("ccw step wrong");
endmodule
`default_nettype wire

// File: hw/gauge_motion.sv
`timescale 1ns/100ps
`default_nettype none
module gauge_motion #(
    parameter int CYC_US = gauge_pkg::CYC_PER_US,
    parameter int RTZ_CYC = gauge_pkg::RTZ_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    input wire logic return_to_zero_active,
    input wire logic zero_hit,
    input wire logic [11:0] tgt,
    output logic [11:0] pos,
    output logic [7:0] vel,
    output logic away,
    output logic dirc,
    output logic rtz_step,
    step_if.src stp
);
    import gauge_pkg::*;
    logic [11:0] pos_d, pos_q, rem;
    logic [7:0] vel_d, vel_q;
    logic [TMR_W-1:0] tmr_d, tmr_q;
    logic dir_d, dir_q, dirc_d, dirc_q, up, step, rstep;
    logic pulse_q, rs_q;

    // =========================================
    // velocity profile and stepping
    always_comb begin
        pos_d = pos_q;
        vel_d = vel_q;
        dir_d = dir_q;
        dirc_d = dirc_q;
        tmr_d = tmr_q;
        step = 1'b0;
        rstep = 1'b0;
        up = tgt > pos_q;
        rem = up ? tgt - pos_q : pos_q - tgt;
        if (!en) begin
            vel_d = 8'h00;
            tmr_d = '0;
        end else if (zero_hit) begin
            pos_d = POS_RESET;
            vel_d = 8'h00;
            tmr_d = '0;
        end else if (tmr_q != '0) begin
            tmr_d = tmr_q - 1'b1;
        end else if (return_to_zero_active) begin
            rstep = 1'b1;
            step = 1'b1;
            dir_d = 1'b0;
            tmr_d = TMR_W'(RTZ_CYC - 1);
        end else if (rem != 12'h000 || vel_q != 8'h00) begin
            if (vel_q == 8'h00) begin
                dir_d = up;
                vel_d = 8'h01;
            end else if (dir_q != up || rem < {4'h0, vel_q}) begin
                vel_d = vel_q - 8'h01;
            end else if (rem > {4'h0, vel_q} && vel_q < VEL_MAX) begin
                vel_d = vel_q + 8'h01;
            end
            step = vel_d != 8'h00;
            if (step) tmr_d = TMR_W'(step_us(vel_d) * CYC_US - 1);
            dirc_d = dir_d != up;
        end
        if (step) pos_d = dir_d ? pos_q + 12'h001 : pos_q - 12'h001;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_q <= POS_RESET;
            vel_q <= 8'h00;
            dir_q <= 1'b0;
            dirc_q <= 1'b0;
            tmr_q <= '0;
            pulse_q <= 1'b0;
            rs_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            vel_q <= vel_d;
            dir_q <= dir_d;
            dirc_q <= dirc_d;
            tmr_q <= tmr_d;
            pulse_q <= step;
            rs_q <= rstep;
        end
    end

    assign pos = pos_q;
    assign vel = vel_q;
    assign away = dir_q;
    assign dirc = dirc_q;
    assign rtz_step = rs_q;
    assign stp.pulse = pulse_q;
    assign stp.cw = dir_q;

    property p_step_move;
        @(posedge clk) disable iff (!rst_b)
        pulse_q |-> pos_q == (dir_q ? $past(pos_q) + 12'h001 : $past(pos_q) - 12'h001);
    endproperty
    a_step_move: assert property (p_step_move) else $error("step without move");

    property p_vel_slew;
        @(posedge clk) disable iff (!rst_b)
        en && !zero_hit |=> vel_q <= VEL_MAX && (vel_q == $past(vel_q) || vel_q == $past(vel_q) + 8'h01 || vel_q == $past(vel_q) - 8'h01);
    endproperty
    a_vel_slew: assert property (p_vel_slew) else $error("velocity jumped");
endmodule
`default_nettype wire

// File: hw/gauge_status_readout.sv
`timescale 1ns/100ps
`default_nettype none
module gauge_status_readout #(
    parameter int CYC_US = gauge_pkg::CYC_PER_US,
    parameter int RTZ_CYC = gauge_pkg::RTZ_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sclk,
    input wire logic si,
    input wire logic heat0,
    input wire logic heat1,
    input wire logic [7:0] bemf,
    output logic so_o,
    output logic so_oe,
    output logic [4:0] phase0,
    output logic [4:0] phase1
);
    import gauge_pkg::*;

    logic [12:0] s1_q, s2_q;
    logic [3:0] prev_q;
    logic cs_s, sclk_s, si_s;
    logic [1:0] heat_s;
    logic [7:0] bemf_s;
    logic cs_fall, cs_rise, sck_rise, sck_fall;
    logic [1:0] trip;

    logic [15:0] sh_d, sh_q, view_w;
    logic so_d, so_q, oe_d, oe_q, nz_d, nz_q;
    logic [3:0] cnt_d, cnt_q;
    logic valid, cmd, poscmd;

    logic [3:0] sel_d, sel_q;
    logic [1:0] active_d, active_q;
    logic [1:0] overheat_flag_d, overheat_flag_q;
    logic [1:0] zero_search_d, zero_search_q;
    logic [1:0] zpend_d, zpend_q;
    logic [1:0] zhit_d, zhit_q;
    logic [1:0] mov_d, mov_q;
    logic [1:0][11:0] tgt_d, tgt_q;
    logic [14:0] zero_search_integral_d, zero_search_integral_q;
    logic [14:0] nacc;
    logic hit_gauge;

    logic [11:0] pointer_location0, pointer_location1;
    logic [7:0] gauge0_speed_index, gauge1_speed_index;
    logic gauge0_heading, gauge1_heading;
    logic gauge0_heading_vs_target, gauge1_heading_vs_target;
    logic gauge0_off_target, gauge1_off_target;
    logic [1:0] rs;
    logic [1:0] run_rtz;

    step_if st0();
    step_if st1();

    // =========================================
    // pin synchronisers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= SYNC_RESET;
            s2_q <= SYNC_RESET;
            prev_q <= PREV_RESET;
        end else begin
            s1_q <= {bemf, heat1, heat0, si, sclk, cs_b};
            s2_q <= s1_q;
            prev_q <= {s2_q[4:3], s2_q[1:0]};
        end
    end

    assign cs_s = s2_q[0];
    assign sclk_s = s2_q[1];
    assign si_s = s2_q[2];
    assign heat_s = s2_q[4:3];
    assign bemf_s = s2_q[12:5];
    assign cs_fall = prev_q[0] & ~cs_s;
    assign cs_rise = ~prev_q[0] & cs_s;
    assign sck_rise = ~prev_q[1] & sclk_s & ~cs_s;
    assign sck_fall = prev_q[1] & ~sclk_s & ~cs_s;
    assign trip = heat_s & ~prev_q[3:2];

    // =========================================
    // serial frame
    always_comb begin
        sh_d = sh_q;
        so_d = so_q;
        oe_d = oe_q;
        cnt_d = cnt_q;
        nz_d = nz_q;
        if (cs_fall) begin
            sh_d = view_w;
            so_d = view_w[15];
            oe_d = 1'b1;
            cnt_d = 4'h0;
            nz_d = 1'b0;
        end else if (cs_rise) begin
            oe_d = 1'b0;
            so_d = 1'b0;
        end else if (sck_rise) begin
            sh_d = {sh_q[14:0], si_s};
            cnt_d = cnt_q + 4'h1;
            nz_d = 1'b1;
        end else if (sck_fall) begin
            so_d = sh_q[15];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_q <= WORD_RESET;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            cnt_q <= 4'h0;
            nz_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            so_q <= so_d;
            oe_q <= oe_d;
            cnt_q <= cnt_d;
            nz_q <= nz_d;
        end
    end

    assign valid = cs_rise & nz_q & (cnt_q == 4'h0);
    assign cmd = valid & ~sh_q[KIND_BIT];
    assign poscmd = valid & sh_q[KIND_BIT];
    assign so_o = so_q;
    assign so_oe = oe_q;

    // =========================================
    // control state and zero search
    always_comb begin
        sel_d = sel_q;
        active_d = active_q;
        overheat_flag_d = overheat_flag_q;
        zero_search_d = zero_search_q;
        zpend_d = zpend_q;
        zhit_d = 2'b00;
        mov_d = mov_q;
        tgt_d = tgt_q;
        zero_search_integral_d = zero_search_integral_q;
        hit_gauge = ~rs[0];
        nacc = zero_search_integral_q + {{7{bemf_s[7]}}, bemf_s};
        if (cmd) sel_d = sh_q[SEL_LSB+3:SEL_LSB];
        for (int g = 0; g < 2; g++) begin
            if (cmd) begin
                active_d[g] = sh_q[EN_LSB+g];
                if (sh_q[EN_LSB+g]) overheat_flag_d[g] = 1'b0;
                if (!sh_q[RTZ_LSB+g]) begin
                    zero_search_d[g] = 1'b0;
                    zpend_d[g] = 1'b0;
                end else if (!zero_search_q[g]) begin
                    zero_search_d[g] = 1'b1;
                    zpend_d[g] = 1'b0;
                    tgt_d[g] = POS_RESET;
                end
            end
            if (poscmd && sh_q[GSEL_BIT] == 1'(g)) tgt_d[g] = sh_q[11:0];
            if (valid) mov_d[g] = 1'b0;
            if (cs_rise && zpend_q[g]) begin
                zero_search_d[g] = 1'b0;
                zpend_d[g] = 1'b0;
            end
            if (trip[g]) begin
                active_d[g] = 1'b0;
                overheat_flag_d[g] = 1'b1;
            end
        end
        if (mov_q[0] | st0.pulse) mov_d[0] = mov_d[0] | st0.pulse;
        if (mov_q[1] | st1.pulse) mov_d[1] = mov_d[1] | st1.pulse;
        if (|rs) begin
            zero_search_integral_d = nacc;
            if (!nacc[14]) begin
                zhit_d[hit_gauge] = 1'b1;
                zpend_d[hit_gauge] = 1'b1;
            end
        end
        if (cmd && (sh_q[RTZ_LSB+1:RTZ_LSB] & ~zero_search_q) != 2'b00)
            zero_search_integral_d = ACC_PRELOAD;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= SEL_RESET;
            active_q <= 2'b00;
            overheat_flag_q <= 2'b00;
            zero_search_q <= 2'b00;
            zpend_q <= 2'b00;
            zhit_q <= 2'b00;
            mov_q <= 2'b00;
            tgt_q <= '0;
            zero_search_integral_q <= ACC_RESET;
        end else begin
            sel_q <= sel_d;
            active_q <= active_d;
            overheat_flag_q <= overheat_flag_d;
            zero_search_q <= zero_search_d;
            zpend_q <= zpend_d;
            zhit_q <= zhit_d;
            mov_q <= mov_d;
            tgt_q <= tgt_d;
            zero_search_integral_q <= zero_search_integral_d;
        end
    end

    assign run_rtz = zero_search_q & ~zpend_q;
    assign gauge0_off_target = pointer_location0 != tgt_q[0];
    assign gauge1_off_target = pointer_location1 != tgt_q[1];

    // =========================================
    // gauges
    gauge_motion #(.CYC_US(CYC_US), .RTZ_CYC(RTZ_CYC)) u_mot0 (
        .clk(clk),
        .rst_b(rst_b),
        .en(active_q[0]),
        .return_to_zero_active(run_rtz[0]),
        .zero_hit(zhit_q[0]),
        .tgt(tgt_q[0]),
        .pos(pointer_location0),
        .vel(gauge0_speed_index),
        .away(gauge0_heading),
        .dirc(gauge0_heading_vs_target),
        .rtz_step(rs[0]),
        .stp(st0.src)
    );

    gauge_motion #(.CYC_US(CYC_US), .RTZ_CYC(RTZ_CYC)) u_mot1 (
        .clk(clk),
        .rst_b(rst_b),
        .en(active_q[1]),
        .return_to_zero_active(run_rtz[1]),
        .zero_hit(zhit_q[1]),
        .tgt(tgt_q[1]),
        .pos(pointer_location1),
        .vel(gauge1_speed_index),
        .away(gauge1_heading),
        .dirc(gauge1_heading_vs_target),
        .rtz_step(rs[1]),
        .stp(st1.src)
    );

    microstep_seq u_seq0 (
        .clk(clk),
        .rst_b(rst_b),
        .stp(st0.dst),
        .phase(phase0)
    );

    microstep_seq u_seq1 (
        .clk(clk),
        .rst_b(rst_b),
        .stp(st1.dst),
        .phase(phase1)
    );

    // =========================================
    // status views, built only from internal state
    always_comb begin
        case (view_of(sel_q))
            VIEW_ACC: view_w = {|zero_search_q, zero_search_integral_q};
            VIEW_POS0: view_w = {active_q[0], gauge0_heading,
                gauge0_heading_vs_target, gauge0_off_target,
                pointer_location0};
            VIEW_POS1: view_w = {active_q[1], gauge1_heading,
                gauge1_heading_vs_target, gauge1_off_target,
                pointer_location1};
            VIEW_VEL: view_w = {gauge1_speed_index, gauge0_speed_index};
            default: view_w = {gauge1_heading, gauge0_heading, 2'b00,
                gauge1_off_target, gauge0_off_target, 4'h0, mov_q,
                zero_search_q, overheat_flag_q};
        endcase
    end

    // =========================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_end;
        cs_rise && nz_q && cnt_q == 4'h0;
    endsequence

    sequence s_sel;
        s_end ##0 !sh_q[KIND_BIT];
    endsequence

    property p_sel;
        s_sel |=> sel_q == $past(sh_q[11:8]);
    endproperty
    a_sel: assert property (p_sel) else $error("selector not taken");

    property p_load;
        cs_fall |=> so_oe && so_o == $past(view_w[15]);
    endproperty
    a_load: assert property (p_load) else $error("view not loaded");

    property p_gauge0_zero_search_active_hold;
        zero_search_q[0] && !cs_rise |=> zero_search_q[0];
    endproperty
    a_gauge0_zero_search_active_hold: assert property (p_gauge0_zero_search_active_hold) else $error("gauge0_zero_search_active dropped");

    property p_gauge1_zero_search_active_hold;
        zero_search_q[1] && !cs_rise |=> zero_search_q[1];
    endproperty
    a_gauge1_zero_search_active_hold: assert property (p_gauge1_zero_search_active_hold) else $error("gauge1_zero_search_active dropped");

    property p_ot0;
        trip[0] |=> overheat_flag_q[0] && !active_q[0];
    endproperty
    a_ot0: assert property (p_ot0) else $error("gauge0 overheat missed");

    property p_ot1;
        trip[1] |=> overheat_flag_q[1] && !active_q[1];
    endproperty
    a_ot1: assert property (p_ot1) else $error("gauge1 overheat missed");

    property p_zero;
        zhit_q[0] |-> !zero_search_integral_q[14] && zpend_q[0];
    endproperty
    a_zero: assert property (p_zero) else $error("zero hit without sign");

    property p_vel;
        cs_fall && view_of(sel_q) == VIEW_VEL
        |=> sh_q == {$past(gauge1_speed_index), $past(gauge0_speed_index)};
    endproperty
    a_vel: assert property (p_vel) else $error("velocity view wrong");

    property p_pos0;
        cs_fall && view_of(sel_q) == VIEW_POS0
        |=> sh_q[11:0] == $past(pointer_location0);
    endproperty
    a_pos0: assert property (p_pos0) else $error("position view wrong");

    property p_oe_off;
        cs_rise |=> !so_oe ##1 !so_oe || cs_fall;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("so still driven");
endmodule
`default_nettype wire

// File: dv/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    input wire logic clk,
    input wire logic so_o,
    input wire logic so_oe,
    output logic cs_b,
    output logic sclk,
    output logic si
);
    // mode 0, msb first, 8 clk per sclk period, bits read on sclk rise
    task automatic frame(input logic [15:0] w, input int nb,
                         output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge clk);
        cs_b = 1'b0;
        for (int i = 0; i < nb; i++) begin
            si = w[15 - i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            // an undriven so line reads as the inverse of its last value
            rd = {rd[14:0], so_oe ? so_o : ~so_o};
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_b = 1'b1;
        // released line shows no stale data
        si = ~si;
        repeat (8) @(negedge clk);
    endtask
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
endmodule
`default_nettype wire

// File: dv/gauge_status_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module gauge_status_readout_tb;
    import gauge_pkg::*;
    logic clk = 0, rst_b = 0, cs_b, sclk, si, heat0 = 0, heat1 = 0;
    logic so_o, so_oe;
    logic [7:0] bemf = 8'h00;
    logic [4:0] phase0, phase1;
    logic [15:0] rd;
    logic [3:0] ctl = 4'h0;
    int miscompares = 0, n_compared = 0, cyc = 0;

    gauge_status_readout #(.CYC_US(1), .RTZ_CYC(40)) gauge_status_readout_i (
        .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .si(si),
        .heat0(heat0), .heat1(heat1), .bemf(bemf), .so_o(so_o),
        .so_oe(so_oe), .phase0(phase0), .phase1(phase1));
    spi_host_model spi_host_model_i (
        .clk(clk), .so_o(so_o), .so_oe(so_oe), .cs_b(cs_b), .sclk(sclk),
        .si(si));

    always #25 clk = ~clk;

    // ==================== tasks
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic xf(input logic [3:0] sel);
        spi_host_model_i.frame({4'h0, sel, 4'h0, ctl}, 16, rd);
    endtask
    // first frame selects, second reads the selected view
    task automatic view(input logic [3:0] sel);
        xf(sel);
        xf(sel);
    endtask
    task automatic fin_t(input string s);
        $display("%0t test %s done", $time, s);
    endtask

    // ==================== watchdog
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            close_out();
        end
    end

    // ==================== tests
    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(phase0, 5'h00)
        `CHK({so_oe, so_o}, 2'h0)
        view(4'h0); `CHK(rd, 16'h0000)
        fin_t("reset");
        ctl = 4'h3;
        view(4'hC); `CHK(rd, 16'h8000)
        view(4'hD); `CHK(rd, 16'h8000)
        // gauge0 heads for 2, gauge1 for 1; first steps are immediate
        spi_host_model_i.frame(16'h8002, 16, rd);
        spi_host_model_i.frame(16'h9001, 16, rd);
        xf(4'hC); `CHK(rd, 16'hc001)
        xf(4'hE); `CHK(rd, 16'hd001)
        xf(4'hF); `CHK(rd, 16'h0101)
        xf(4'hC); `CHK(rd, 16'h0101)
        `CHK(phase1, 5'h01)
        for (int k = 0; k < 40 && rd[11:0] !== 12'h002; k++) begin
            repeat (1000) @(negedge clk);
            xf(4'hC);
        end
        `CHK(rd & 16'h9fff, 16'h8002)
        `CHK(phase0, 5'h02)
        fin_t("motion");
        heat0 = 1'b1;
        heat1 = 1'b1;
        repeat (6) @(negedge clk);
        heat0 = 1'b0;
        heat1 = 1'b0;
        ctl = 4'h0;
        view(4'h0); `CHK(rd & 16'h000f, 16'h0003)
        xf(4'h0); `CHK(rd & 16'h000f, 16'h0003)
        ctl = 4'h3;
        view(4'h0); `CHK(rd & 16'h000f, 16'h0000)
        fin_t("overheat");
        ctl = 4'hB;
        view(4'h0); `CHK(rd & 16'h000f, 16'h0008)
        ctl = 4'h3;
        view(4'h0); `CHK(rd & 16'h000f, 16'h0000)
        ctl = 4'h7;
        view(4'h8); `CHK(rd, 16'hffff)
        bemf = 8'h02;
        repeat (200) @(negedge clk);
        ctl = 4'h3;
        xf(4'h8); `CHK(rd, 16'h8001)
        xf(4'h8); `CHK(rd, 16'h0001)
        spi_host_model_i.frame(16'h0e00, 8, rd);
        xf(4'h8); `CHK(rd, 16'h0001)
        view(4'hC); `CHK(rd & 16'h0fff, 16'h0000)
        fin_t("zero search");
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        ctl = 4'h0;
        view(4'h8); `CHK(rd, 16'h0000)
        `CHK(phase1, 5'h00)
        fin_t("second reset");
        close_out();
    end
endmodule
`default_nettype wire
